// File: verilog/dacc_regs.svh
// constants for the accumulator datapath: field positions, limits, reset values
// assumes inclusion by the round/saturation and datapath modules; definitions only
//
// What this block does
// - 40-bit adder with sign extension; one accumulator is source and destination.
// - add uses true data, carry high; subtract complements data, borrow low.
// - guard overflow flagged when result bits 32 to 39 differ.
// - target accumulator's guard flag rewritten every adder operation; enabled flag raises warning trap.
// - saturation flags set on range overflow and stay set until cleared.
// - saturation off: flags mean bit 39 overflow; trap when catastrophic enable set.
// - combined bits are OR of guard flags and OR of saturation flags.
// - bit 31 mode replaces overflow with max or min 1.31 value by true sign and sets flag.
// - bit 31 mode never sets any guard overflow flag.
// - catastrophic mode wraps, sets sticky flag, may trap when enabled.
// - saturation uses result, overflow, per-accumulator enables and mode select.
// - multiply-accumulate ops, not plain, negated or squared, may write back.
// - write-back direct into pointer, or indirect with pointer plus two.
// - conventional rounding adds bit 15 into the high word.
// - convergent rounding: low word exactly half rounds by bit 16.
// - rounding-mode bit picks rounding; no rounding stores truncated high word.
// - plain store truncates, rounded store rounds, write-back always rounds.
// - data-write saturation clamps to 0x7FFF or 0x8000 by bit 39 sign.
// - data-write saturation off passes rounded or truncated value unmodified.
// - shifter does arithmetic, logical right or left shifts up to 16.
// - signed amount: positive right, negative left, zero unchanged.
// - 40-bit shifter; X bus enters at 16..31 right, 0..15 left.
`ifndef DACC_REGS_SVH
`define DACC_REGS_SVH

`define DACC_SIGN_BIT   39
`define DACC_GUARD_LO   32
`define DACC_B31        31
`define DACC_HI_LSB     16
`define DACC_RND_BIT    15
`define DACC_ACC_RST    40'h00_0000_0000
`define DACC_MAX31      40'h00_7FFF_FFFF
`define DACC_MIN31      40'hFF_8000_0000
`define DACC_MAX40      40'h7F_FFFF_FFFF
`define DACC_MIN40      40'h80_0000_0000
`define DACC_HALF_LSB   16'h8000
`define DACC_DW_MAX     16'h7FFF
`define DACC_DW_MIN     16'h8000
`define DACC_WORD_RST   16'h0000
`define DACC_PTR_STEP   16'h0002
`define DACC_SHIFT_MAX  6'h10

`endif

// File: verilog/dacc_pkg.sv
// types shared by the accumulator datapath files
// assumes nothing beyond a SystemVerilog compiler
package dacc_pkg;
  typedef logic [39:0] dacc_acc_t;
  typedef logic [15:0] dacc_word_t;
  typedef enum logic [3:0] {
    DACC_OP_NOP, DACC_OP_ADD, DACC_OP_SUB, DACC_OP_LOAD, DACC_OP_MAC,
    DACC_OP_MPY, DACC_OP_STORE, DACC_OP_STORE_RND, DACC_OP_SHIFT
  } dacc_op_t;
  typedef enum logic [1:0] {DACC_WB_NONE, DACC_WB_DIRECT, DACC_WB_INDIRECT} dacc_wb_mode_t;
endpackage

// File: verilog/dacc_wb_if.sv
// carrier between datapath and round/write-saturation logic
// assumes the datapath drives acc and controls, and reads back data
`timescale 1ns/100ps
interface dacc_wb_if;
  dacc_pkg::dacc_acc_t  acc;
  logic                 round_en;
  logic                 convergent;
  logic                 sat_en;
  dacc_pkg::dacc_word_t data;
  modport src (output acc, output round_en, output convergent, output sat_en, input data);
  modport rnd (input acc, input round_en, input convergent, input sat_en, output data);
endinterface

// File: verilog/dacc_round_sat.sv
// round logic and data-space write saturation, purely combinational
// assumes the caller picks source accumulator and rounding request
`timescale 1ns/100ps
`include "dacc_regs.svh"
module dacc_round_sat (
  dacc_wb_if.rnd wb
);
  wire        lo_is_half = (wb.acc[`DACC_HI_LSB-1:0] == `DACC_HALF_LSB);
  wire        conv_inc   = lo_is_half ? wb.acc[`DACC_HI_LSB] : wb.acc[`DACC_RND_BIT];
  wire        rnd_inc    = wb.convergent ? conv_inc : wb.acc[`DACC_RND_BIT];
  wire        inc        = wb.round_en & rnd_inc;
  // carry up through the guard bits so the clamp sees the rounded magnitude
  wire [23:0] ext_val    = wb.acc[`DACC_SIGN_BIT:`DACC_HI_LSB] + {23'h000000, inc};
  wire        src_neg    = wb.acc[`DACC_SIGN_BIT];
  wire        pos_ovf    = !src_neg && (ext_val[23:15] != 9'h000);
  wire        neg_ovf    = src_neg && (ext_val[23:15] != 9'h1FF);
  wire [15:0] clamped    = pos_ovf ? `DACC_DW_MAX : (neg_ovf ? `DACC_DW_MIN : ext_val[15:0]);
  assign wb.data = wb.sat_en ? clamped : ext_val[15:0];
endmodule

// File: verilog/dacc_datapath.sv
// accumulator datapath: 40-bit add/sub, accumulator saturation, status, rounded
// store and write-back, 40-bit barrel shifter
// assumes decode presents one operation per clk with all operands valid that cycle
`timescale 1ns/100ps
`include "dacc_regs.svh"
module dacc_datapath (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      op_valid,
  input  wire dacc_pkg::dacc_op_t        op_code,
  input  wire logic                      acc_sel,
  input  wire dacc_pkg::dacc_acc_t       operand,
  input  wire logic                      use_shifter,
  input  wire logic                      shift_from_xbus,
  input  wire logic                      shift_acc_sel,
  input  wire logic signed [5:0]         shift_amt,
  input  wire logic                      shift_logical,
  input  wire dacc_pkg::dacc_word_t      xbus_data,
  input  wire dacc_pkg::dacc_wb_mode_t   wb_mode,
  input  wire dacc_pkg::dacc_word_t      writeback_pointer_reg,
  input  wire dacc_pkg::dacc_word_t      store_addr,
  input  wire logic                      acc_a_sat_enable,
  input  wire logic                      acc_b_sat_enable,
  input  wire logic                      acc_sat_mode_select,
  input  wire logic                      data_write_sat_enable,
  input  wire logic                      rounding_mode_select,
  input  wire logic                      acc_a_overflow_trap_en,
  input  wire logic                      acc_b_overflow_trap_en,
  input  wire logic                      catastrophic_trap_en,
  input  wire logic                      clr_acc_a_saturated,
  input  wire logic                      clr_acc_b_saturated,
  output wire dacc_pkg::dacc_acc_t       acc_a,
  output wire dacc_pkg::dacc_acc_t       acc_b,
  output wire logic                      acc_a_saturated,
  output wire logic                      acc_b_saturated,
  output wire logic                      acc_a_guard_overflow,
  output wire logic                      acc_b_guard_overflow,
  output wire logic                      any_guard_overflow,
  output wire logic                      any_saturated,
  output wire logic                      arith_trap,
  output wire dacc_pkg::dacc_acc_t       shift_result,
  output wire dacc_pkg::dacc_word_t      mcu_shift_result,
  output wire logic                      mem_we,
  output wire dacc_pkg::dacc_word_t      mem_addr,
  output wire dacc_pkg::dacc_word_t      mem_data,
  output wire logic                      wptr_we,
  output wire dacc_pkg::dacc_word_t      wptr_data
);
  dacc_pkg::dacc_acc_t  acc_a_ff;
  dacc_pkg::dacc_acc_t  acc_b_ff;
  logic                 acc_a_saturated_ff;
  logic                 acc_b_saturated_ff;
  logic                 acc_a_guard_overflow_ff;
  logic                 acc_b_guard_overflow_ff;
  logic                 any_guard_overflow_ff;
  logic                 any_saturated_ff;
  logic                 arith_trap_ff;
  dacc_pkg::dacc_acc_t  shift_result_ff;
  dacc_pkg::dacc_word_t mcu_shift_result_ff;
  logic                 mem_we_ff;
  dacc_pkg::dacc_word_t mem_addr_ff;
  dacc_pkg::dacc_word_t mem_data_ff;
  logic                 wptr_we_ff;
  dacc_pkg::dacc_word_t wptr_data_ff;

  // operation decode
  wire op_add   = op_valid && (op_code == dacc_pkg::DACC_OP_ADD);
  wire op_sub   = op_valid && (op_code == dacc_pkg::DACC_OP_SUB);
  wire op_load  = op_valid && (op_code == dacc_pkg::DACC_OP_LOAD);
  wire op_mac   = op_valid && (op_code == dacc_pkg::DACC_OP_MAC);
  wire op_mpy   = op_valid && (op_code == dacc_pkg::DACC_OP_MPY);
  wire op_st    = op_valid && (op_code == dacc_pkg::DACC_OP_STORE);
  wire op_st_r  = op_valid && (op_code == dacc_pkg::DACC_OP_STORE_RND);
  wire op_shift = op_valid && (op_code == dacc_pkg::DACC_OP_SHIFT);
  wire adder_op = op_add | op_sub | op_load | op_mac | op_mpy;
  wire sel_a    = adder_op && !acc_sel;
  wire sel_b    = adder_op && acc_sel;

  // barrel shifter
  wire        sh_left = shift_amt[5];
  wire [5:0]  sh_raw  = sh_left ? 6'(-shift_amt) : 6'(shift_amt);
  wire [5:0]  sh_mag  = (sh_raw > `DACC_SHIFT_MAX) ? `DACC_SHIFT_MAX : sh_raw;
  // left shifts take the word low so bit 16 carries its sign; right shifts take it mid-word
  wire dacc_pkg::dacc_acc_t xb_left  = {{24{xbus_data[15]}}, xbus_data};
  wire dacc_pkg::dacc_acc_t xb_right = {{8{xbus_data[15]}}, xbus_data, 16'h0000};
  wire dacc_pkg::dacc_acc_t xb_word  = sh_left ? xb_left : xb_right;
  wire dacc_pkg::dacc_acc_t sh_acc   = shift_acc_sel ? acc_b_ff : acc_a_ff;
  wire dacc_pkg::dacc_acc_t sh_src   = shift_from_xbus ? xb_word : sh_acc;
  wire dacc_pkg::dacc_acc_t sh_arith = 40'($signed(sh_src) >>> sh_mag);
  wire dacc_pkg::dacc_acc_t sh_logic = sh_src >> sh_mag;
  wire dacc_pkg::dacc_acc_t sh_lft   = sh_src << sh_mag;
  wire dacc_pkg::dacc_acc_t sh_res   = sh_left ? sh_lft : (shift_logical ? sh_logic : sh_arith);
  wire dacc_pkg::dacc_word_t sh_mcu  = sh_left ? sh_res[15:0] : sh_res[31:16];

  // adder/subtracter
  wire dacc_pkg::dacc_acc_t tgt_acc = acc_sel ? acc_b_ff : acc_a_ff;
  wire dacc_pkg::dacc_acc_t opnd    = use_shifter ? sh_res : operand;
  wire dacc_pkg::dacc_acc_t a_in    = (op_load | op_mpy) ? `DACC_ACC_RST : tgt_acc;
  wire dacc_pkg::dacc_acc_t b_in    = op_sub ? ~opnd : opnd;
  // borrow is active low, so subtract feeds a carry of one when nothing is borrowed
  wire        cin     = op_sub;
  wire [40:0] sum41   = {a_in[39], a_in} + {b_in[39], b_in} + {40'h00_0000_0000, cin};
  wire dacc_pkg::dacc_acc_t raw = sum41[39:0];
  wire        true_neg  = sum41[40];
  wire        ovf39     = sum41[40] ^ sum41[39];
  wire [7:0]  guard     = raw[`DACC_SIGN_BIT:`DACC_GUARD_LO];
  wire        guard_mix = !((&guard) || !(|guard));
  wire [8:0]  top9      = raw[`DACC_SIGN_BIT:`DACC_B31];
  wire        fit31     = ((&top9) || !(|top9)) && !ovf39;

  // saturation block
  wire        sat_en   = acc_sel ? acc_b_sat_enable : acc_a_sat_enable;
  wire        mode39   = acc_sat_mode_select;
  wire        sat_hit  = sat_en ? (mode39 ? ovf39 : !fit31) : ovf39;
  wire dacc_pkg::dacc_acc_t sat31 = true_neg ? `DACC_MIN31 : `DACC_MAX31;
  wire dacc_pkg::dacc_acc_t sat40 = true_neg ? `DACC_MIN40 : `DACC_MAX40;
  wire dacc_pkg::dacc_acc_t acc_res = (sat_en && sat_hit) ? (mode39 ? sat40 : sat31) : raw;
  wire        guard_flag = (sat_en && !mode39) ? 1'b0 : guard_mix;
  wire        gtrap_en   = acc_sel ? acc_b_overflow_trap_en : acc_a_overflow_trap_en;
  wire        nxt_arith_trap = adder_op && ((guard_flag && gtrap_en) ||
                               (!sat_en && ovf39 && catastrophic_trap_en));

  wire dacc_pkg::dacc_acc_t nxt_acc_a = sel_a ? acc_res : acc_a_ff;
  wire dacc_pkg::dacc_acc_t nxt_acc_b = sel_b ? acc_res : acc_b_ff;
  wire nxt_acc_a_guard_overflow = sel_a ? guard_flag : acc_a_guard_overflow_ff;
  wire nxt_acc_b_guard_overflow = sel_b ? guard_flag : acc_b_guard_overflow_ff;
  // set wins over a software clear in the same cycle
  wire nxt_acc_a_saturated = (sel_a && sat_hit) ||
                             (acc_a_saturated_ff && !clr_acc_a_saturated);
  wire nxt_acc_b_saturated = (sel_b && sat_hit) ||
                             (acc_b_saturated_ff && !clr_acc_b_saturated);

  // store and write-back; plain, negated and squared multiplies never write back
  wire wb_any   = op_mac && (wb_mode != dacc_pkg::DACC_WB_NONE);
  wire wb_dir   = op_mac && (wb_mode == dacc_pkg::DACC_WB_DIRECT);
  wire wb_ind   = op_mac && (wb_mode == dacc_pkg::DACC_WB_INDIRECT);
  wire store_op = op_st | op_st_r;
  wire dacc_pkg::dacc_acc_t other_acc = acc_sel ? acc_a_ff : acc_b_ff;

  dacc_wb_if wbi ();
  assign wbi.acc        = wb_any ? other_acc : tgt_acc;
  assign wbi.round_en   = wb_any | op_st_r;
  assign wbi.convergent = rounding_mode_select;
  assign wbi.sat_en     = data_write_sat_enable;

  dacc_round_sat u_round_sat (
    .wb (wbi.rnd)
  );

  wire nxt_mem_we  = store_op | wb_ind;
  wire dacc_pkg::dacc_word_t nxt_mem_addr = store_op ? store_addr : writeback_pointer_reg;
  wire nxt_wptr_we = wb_dir | wb_ind;
  wire dacc_pkg::dacc_word_t nxt_wptr_data =
    wb_dir ? wbi.data : writeback_pointer_reg + `DACC_PTR_STEP;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_a_ff <= `DACC_ACC_RST;
      acc_b_ff <= `DACC_ACC_RST;
    end else begin
      acc_a_ff <= nxt_acc_a;
      acc_b_ff <= nxt_acc_b;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_a_saturated_ff      <= 1'b0;
      acc_b_saturated_ff      <= 1'b0;
      acc_a_guard_overflow_ff <= 1'b0;
      acc_b_guard_overflow_ff <= 1'b0;
      any_guard_overflow_ff   <= 1'b0;
      any_saturated_ff        <= 1'b0;
      arith_trap_ff           <= 1'b0;
    end else begin
      acc_a_saturated_ff      <= nxt_acc_a_saturated;
      acc_b_saturated_ff      <= nxt_acc_b_saturated;
      acc_a_guard_overflow_ff <= nxt_acc_a_guard_overflow;
      acc_b_guard_overflow_ff <= nxt_acc_b_guard_overflow;
      any_guard_overflow_ff   <= nxt_acc_a_guard_overflow | nxt_acc_b_guard_overflow;
      any_saturated_ff        <= nxt_acc_a_saturated | nxt_acc_b_saturated;
      arith_trap_ff           <= nxt_arith_trap;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_result_ff     <= `DACC_ACC_RST;
      mcu_shift_result_ff <= `DACC_WORD_RST;
    end else if (op_shift) begin
      shift_result_ff     <= sh_res;
      mcu_shift_result_ff <= sh_mcu;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we_ff    <= 1'b0;
      mem_addr_ff  <= `DACC_WORD_RST;
      mem_data_ff  <= `DACC_WORD_RST;
      wptr_we_ff   <= 1'b0;
      wptr_data_ff <= `DACC_WORD_RST;
    end else begin
      mem_we_ff    <= nxt_mem_we;
      wptr_we_ff   <= nxt_wptr_we;
      if (nxt_mem_we) begin
        mem_addr_ff <= nxt_mem_addr;
        mem_data_ff <= wbi.data;
      end
      if (nxt_wptr_we) begin
        wptr_data_ff <= nxt_wptr_data;
      end
    end
  end

  assign acc_a                = acc_a_ff;
  assign acc_b                = acc_b_ff;
  assign acc_a_saturated      = acc_a_saturated_ff;
  assign acc_b_saturated      = acc_b_saturated_ff;
  assign acc_a_guard_overflow = acc_a_guard_overflow_ff;
  assign acc_b_guard_overflow = acc_b_guard_overflow_ff;
  assign any_guard_overflow   = any_guard_overflow_ff;
  assign any_saturated        = any_saturated_ff;
  assign arith_trap           = arith_trap_ff;
  assign shift_result         = shift_result_ff;
  assign mcu_shift_result     = mcu_shift_result_ff;
  assign mem_we               = mem_we_ff;
  assign mem_addr             = mem_addr_ff;
  assign mem_data             = mem_data_ff;
  assign wptr_we              = wptr_we_ff;
  assign wptr_data            = wptr_data_ff;

  // checks
  sequence s_wb_indirect;
    op_mac && (wb_mode == dacc_pkg::DACC_WB_INDIRECT);
  endsequence

  sequence s_ptr_bumped;
    wptr_we && mem_we && (wptr_data == $past(writeback_pointer_reg) + `DACC_PTR_STEP);
  endsequence

  property p_ptr_step;
    @(posedge clk) disable iff (!rst_n)
    s_wb_indirect |=> s_ptr_bumped;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("indirect write-back did not bump pointer by two");

  property p_no_guard_31;
    @(posedge clk) disable iff (!rst_n)
    (sel_a && acc_a_sat_enable && !acc_sat_mode_select) |=> !acc_a_guard_overflow;
  endproperty
  a_no_guard_31: assert property (p_no_guard_31)
    else $error("guard flag set in bit 31 saturation mode");

  property p_any_sat;
    @(posedge clk) disable iff (!rst_n)
    any_saturated == (acc_a_saturated || acc_b_saturated);
  endproperty
  a_any_sat: assert property (p_any_sat)
    else $error("combined saturation bit disagrees with flags");

  property p_sat_sticky;
    @(posedge clk) disable iff (!rst_n)
    (acc_a_saturated && !clr_acc_a_saturated) |=> acc_a_saturated;
  endproperty
  a_sat_sticky: assert property (p_sat_sticky)
    else $error("saturation flag dropped without a clear");

  property p_sat31_pos;
    @(posedge clk) disable iff (!rst_n)
    (sel_a && acc_a_sat_enable && !mode39 && !fit31 && !true_neg)
      |=> (acc_a == `DACC_MAX31) && acc_a_saturated;
  endproperty
  a_sat31_pos: assert property (p_sat31_pos)
    else $error("bit 31 saturation value wrong");

  property p_wrap39;
    @(posedge clk) disable iff (!rst_n)
    (sel_a && !acc_a_sat_enable && ovf39) |=> (acc_a == $past(raw)) && acc_a_saturated;
  endproperty
  a_wrap39: assert property (p_wrap39)
    else $error("catastrophic overflow did not wrap and flag");

  property p_guard_trap;
    @(posedge clk) disable iff (!rst_n)
    (adder_op && guard_flag && gtrap_en)
      |=> arith_trap && ($past(acc_sel) ? acc_b_guard_overflow : acc_a_guard_overflow);
  endproperty
  a_guard_trap: assert property (p_guard_trap)
    else $error("guard overflow trap missing");

  property p_mpy_no_wb;
    @(posedge clk) disable iff (!rst_n)
    op_mpy |=> !mem_we && !wptr_we;
  endproperty
  a_mpy_no_wb: assert property (p_mpy_no_wb)
    else $error("plain multiply wrote back");

  property p_dw_clamp;
    @(posedge clk) disable iff (!rst_n)
    (op_st && !acc_sel && data_write_sat_enable && !acc_a[39] && (acc_a[38:31] != 8'h00))
      |=> mem_we && (mem_data == `DACC_DW_MAX);
  endproperty
  a_dw_clamp: assert property (p_dw_clamp)
    else $error("data write saturation did not clamp positive");

  property p_shift_zero;
    @(posedge clk) disable iff (!rst_n)
    (op_shift && (shift_amt == 6'sd0) && !shift_from_xbus) |=> shift_result == $past(sh_acc);
  endproperty
  a_shift_zero: assert property (p_shift_zero)
    else $error("zero shift altered operand");
endmodule

// File: bench/dacc_mem_model.sv
// far-side model: write-back pointer register fed by the datapath
// assumes pointer writes arrive as one-cycle enables on clk
`timescale 1ns/100ps
module dacc_mem_model (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 wptr_we,
  input  wire dacc_pkg::dacc_word_t wptr_data,
  output dacc_pkg::dacc_word_t      wptr_ff
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_ff <= 16'h0100;
    end else if (wptr_we) begin
      wptr_ff <= wptr_data;
    end
  end
endmodule

// File: bench/dacc_datapath_bench.sv
// self-checking bench for the accumulator datapath
// assumes the pointer model answers write-back; one op every second clk
`timescale 1ns/100ps
module dacc_datapath_bench;
  logic clk, rst_n, op_valid, acc_sel, use_shifter, shift_from_xbus, shift_acc_sel;
  logic shift_logical, acc_a_sat_enable, acc_b_sat_enable, acc_sat_mode_select;
  logic data_write_sat_enable, rounding_mode_select, acc_a_overflow_trap_en;
  logic acc_b_overflow_trap_en, catastrophic_trap_en, clr_acc_a_saturated;
  logic clr_acc_b_saturated, acc_a_saturated, acc_b_saturated, acc_a_guard_overflow;
  logic acc_b_guard_overflow, any_guard_overflow, any_saturated, arith_trap, mem_we, wptr_we;
  logic signed [5:0]       shift_amt;
  dacc_pkg::dacc_op_t      op_code;
  dacc_pkg::dacc_wb_mode_t wb_mode;
  dacc_pkg::dacc_acc_t     operand, acc_a, acc_b, shift_result;
  dacc_pkg::dacc_word_t    xbus_data, store_addr, mcu_shift_result, mem_addr, mem_data;
  dacc_pkg::dacc_word_t    wptr_data, wptr;
  int                      fail_count, n_tests;

  dacc_datapath dut (.clk, .rst_n, .op_valid, .op_code, .acc_sel, .operand, .use_shifter,
    .shift_from_xbus, .shift_acc_sel, .shift_amt, .shift_logical, .xbus_data, .wb_mode,
    .writeback_pointer_reg(wptr), .store_addr, .acc_a_sat_enable, .acc_b_sat_enable,
    .acc_sat_mode_select, .data_write_sat_enable, .rounding_mode_select,
    .acc_a_overflow_trap_en, .acc_b_overflow_trap_en, .catastrophic_trap_en,
    .clr_acc_a_saturated, .clr_acc_b_saturated, .acc_a, .acc_b, .acc_a_saturated,
    .acc_b_saturated, .acc_a_guard_overflow, .acc_b_guard_overflow, .any_guard_overflow,
    .any_saturated, .arith_trap, .shift_result, .mcu_shift_result, .mem_we, .mem_addr,
    .mem_data, .wptr_we, .wptr_data);
  dacc_mem_model mem (.clk, .rst_n, .wptr_we, .wptr_data, .wptr_ff(wptr));

  always #2.5 clk = ~clk;

  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // an idle edge first, so op_valid never drops and rises in one time step
  task automatic op(input dacc_pkg::dacc_op_t c, input logic s, input dacc_pkg::dacc_acc_t d);
    @(posedge clk);
    #1;
    op_valid = 1'h1;
    op_code = c;
    acc_sel = s;
    operand = d;
    @(posedge clk);
    #1 op_valid = 1'h0;
  endtask

  task automatic clr_a();
    clr_acc_a_saturated = 1'h1;
    @(posedge clk);
    #1 clr_acc_a_saturated = 1'h0;
    chk("sat_a", 1'h0, acc_a_saturated);
  endtask

  task automatic sh(input logic x, input logic signed [5:0] a, input logic l);
    shift_from_xbus = x;
    shift_amt = a;
    shift_logical = l;
    op(dacc_pkg::DACC_OP_SHIFT, 1'h0, 40'h0);
  endtask

  task automatic t_sat();
    acc_a_sat_enable = 1'h1;
    op(dacc_pkg::DACC_OP_LOAD, 1'h0, 40'h00_7FFF_FFF0);
    op(dacc_pkg::DACC_OP_ADD, 1'h0, 40'h00_0000_0020);
    chk("acc_a", 40'h00_7FFF_FFFF, acc_a);
    chk("guard_a", 1'h0, acc_a_guard_overflow);
    op(dacc_pkg::DACC_OP_SUB, 1'h0, 40'h00_0000_0001);
    chk("any_sat", 1'h1, any_saturated);
    clr_a();
    acc_sat_mode_select = 1'h1;
    op(dacc_pkg::DACC_OP_LOAD, 1'h0, 40'h80_0000_0010);
    op(dacc_pkg::DACC_OP_SUB, 1'h0, 40'h00_0000_0020);
    chk("acc_a", 40'h80_0000_0000, acc_a);
    chk("sat_a", 1'h1, acc_a_saturated);
    clr_a();
    acc_a_sat_enable = 1'h0;
    catastrophic_trap_en = 1'h1;
    op(dacc_pkg::DACC_OP_LOAD, 1'h0, 40'h7F_FFFF_FFFF);
    op(dacc_pkg::DACC_OP_ADD, 1'h0, 40'h00_0000_0001);
    chk("acc_a", 40'h80_0000_0000, acc_a);
    chk("trap", 1'h1, arith_trap);
    chk("any_sat", 1'h1, any_saturated);
    clr_a();
    catastrophic_trap_en = 1'h0;
  endtask

  task automatic t_guard();
    acc_b_overflow_trap_en = 1'h1;
    op(dacc_pkg::DACC_OP_LOAD, 1'h1, 40'h01_0000_0000);
    chk("guard_b", 1'h1, acc_b_guard_overflow);
    chk("any_guard", 1'h1, any_guard_overflow);
    chk("trap", 1'h1, arith_trap);
    op(dacc_pkg::DACC_OP_LOAD, 1'h1, 40'h0);
    op(dacc_pkg::DACC_OP_SUB, 1'h1, 40'h00_0000_0001);
    chk("acc_b", 40'hFF_FFFF_FFFF, acc_b);
    chk("guard_b", 1'h0, acc_b_guard_overflow);
    acc_b_overflow_trap_en = 1'h0;
    op(dacc_pkg::DACC_OP_LOAD, 1'h1, 40'h01_0000_0000);
    chk("guard_b", 1'h1, acc_b_guard_overflow);
    chk("trap", 1'h0, arith_trap);
  endtask

  task automatic t_sat_b();
    acc_b_sat_enable = 1'h1;
    shift_from_xbus = 1'h0;
    shift_acc_sel = 1'h1;
    shift_amt = 6'sh00;
    op(dacc_pkg::DACC_OP_LOAD, 1'h1, 40'h60_0000_0000);
    use_shifter = 1'h1;
    op(dacc_pkg::DACC_OP_ADD, 1'h1, 40'h0);
    use_shifter = 1'h0;
    chk("acc_b", 40'h7F_FFFF_FFFF, acc_b);
    chk("sat_b", 1'h1, acc_b_saturated);
    clr_acc_b_saturated = 1'h1;
    @(posedge clk);
    #1 clr_acc_b_saturated = 1'h0;
    chk("sat_b", 1'h0, acc_b_saturated);
  endtask

  task automatic t_store();
    store_addr = 16'h0040;
    op(dacc_pkg::DACC_OP_LOAD, 1'h0, 40'h00_1234_8000);
    op(dacc_pkg::DACC_OP_STORE, 1'h0, 40'h0);
    chk("mem_we", 1'h1, mem_we);
    chk("mem_addr", 16'h0040, mem_addr);
    chk("mem_data", 16'h1234, mem_data);
    op(dacc_pkg::DACC_OP_STORE_RND, 1'h0, 40'h0);
    chk("mem_data", 16'h1235, mem_data);
    rounding_mode_select = 1'h1;
    op(dacc_pkg::DACC_OP_STORE_RND, 1'h0, 40'h0);
    chk("mem_data", 16'h1234, mem_data);
    op(dacc_pkg::DACC_OP_LOAD, 1'h0, 40'h00_1235_8000);
    op(dacc_pkg::DACC_OP_STORE_RND, 1'h0, 40'h0);
    chk("mem_data", 16'h1236, mem_data);
    rounding_mode_select = 1'h0;
    data_write_sat_enable = 1'h1;
    op(dacc_pkg::DACC_OP_LOAD, 1'h0, 40'h00_9000_0000);
    op(dacc_pkg::DACC_OP_STORE, 1'h0, 40'h0);
    chk("mem_data", 16'h7FFF, mem_data);
    chk("acc_a", 40'h00_9000_0000, acc_a);
    op(dacc_pkg::DACC_OP_LOAD, 1'h0, 40'hFF_7000_0000);
    op(dacc_pkg::DACC_OP_STORE, 1'h0, 40'h0);
    chk("mem_data", 16'h8000, mem_data);
    data_write_sat_enable = 1'h0;
    op(dacc_pkg::DACC_OP_STORE, 1'h0, 40'h0);
    chk("mem_data", 16'h7000, mem_data);
  endtask

  task automatic t_wb();
    op(dacc_pkg::DACC_OP_LOAD, 1'h1, 40'h00_2222_8000);
    op(dacc_pkg::DACC_OP_LOAD, 1'h0, 40'h0);
    wb_mode = dacc_pkg::DACC_WB_INDIRECT;
    op(dacc_pkg::DACC_OP_MAC, 1'h0, 40'h00_0000_0003);
    chk("acc_a", 40'h00_0000_0003, acc_a);
    chk("mem_addr", 16'h0100, mem_addr);
    chk("mem_data", 16'h2223, mem_data);
    chk("wptr_data", 16'h0102, wptr_data);
    op(dacc_pkg::DACC_OP_MPY, 1'h0, 40'h00_0000_0001);
    chk("mem_we", 1'h0, mem_we);
    chk("wptr", 16'h0102, wptr);
    wb_mode = dacc_pkg::DACC_WB_DIRECT;
    op(dacc_pkg::DACC_OP_MAC, 1'h0, 40'h00_0000_0001);
    chk("wptr_data", 16'h2223, wptr_data);
    wb_mode = dacc_pkg::DACC_WB_NONE;
  endtask

  task automatic t_shift();
    op(dacc_pkg::DACC_OP_LOAD, 1'h0, 40'h80_0000_0000);
    op(dacc_pkg::DACC_OP_LOAD, 1'h1, 40'h00_0000_1234);
    sh(1'h0, 6'sh04, 1'h0);
    chk("shift", 40'hF8_0000_0000, shift_result);
    sh(1'h0, 6'sh04, 1'h1);
    chk("shift", 40'h08_0000_0000, shift_result);
    sh(1'h0, 6'sh00, 1'h0);
    chk("shift", 40'h80_0000_0000, shift_result);
    shift_acc_sel = 1'h1;
    sh(1'h0, 6'sh30, 1'h0); // minus sixteen
    chk("shift", 40'h00_1234_0000, shift_result);
    xbus_data = 16'h1234;
    sh(1'h1, 6'sh3C, 1'h0); // minus four
    chk("mcu_shift", 16'h2340, mcu_shift_result);
    xbus_data = 16'h8000;
    sh(1'h1, 6'sh04, 1'h0);
    chk("shift", 40'hFF_F800_0000, shift_result);
  endtask

  initial begin
    {clk, rst_n, op_valid, acc_sel, use_shifter, shift_from_xbus, shift_acc_sel} = '0;
    {shift_logical, acc_a_sat_enable, acc_b_sat_enable, acc_sat_mode_select} = '0;
    {data_write_sat_enable, rounding_mode_select, acc_a_overflow_trap_en} = '0;
    {acc_b_overflow_trap_en, catastrophic_trap_en, clr_acc_a_saturated} = '0;
    {clr_acc_b_saturated, shift_amt, operand, xbus_data, store_addr} = '0;
    op_code = dacc_pkg::DACC_OP_NOP;
    wb_mode = dacc_pkg::DACC_WB_NONE;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'h1;
    t_sat();
    t_guard();
    t_store();
    t_wb();
    t_shift();
    t_sat_b();
    close_out();
  end

  // the sequence needs well under 200 cycles
  initial begin
    #5000;
    fail_count++;
    close_out();
  end
endmodule
